//--- hdl/tlfo_pkg.sv
// Shared constants and carriers for the thermal limit / fan override block.
// Assumes one system clock; register indices become byte offsets times four.
package tlfo_pkg;

  localparam int NUM_CHAN = 3;

  // Register indices; byte address on APB is the index times four
  localparam logic [7:0] IDX_OP_R1 = 8'h33;
  localparam logic [7:0] IDX_OP_LOC = 8'h34;
  localparam logic [7:0] IDX_OP_R2 = 8'h35;
  localparam logic [7:0] IDX_LOW_R1 = 8'h4e;
  localparam logic [7:0] IDX_HIGH_R1 = 8'h4f;
  localparam logic [7:0] IDX_LOW_LOC = 8'h50;
  localparam logic [7:0] IDX_HIGH_LOC = 8'h51;
  localparam logic [7:0] IDX_LOW_R2 = 8'h52;
  localparam logic [7:0] IDX_HIGH_R2 = 8'h53;
  localparam logic [7:0] IDX_KEEPALIVE = 8'h62;
  localparam logic [7:0] IDX_CRIT_R1 = 8'h6a;
  localparam logic [7:0] IDX_CRIT_LOC = 8'h6b;
  localparam logic [7:0] IDX_CRIT_R2 = 8'h6c;
  localparam logic [7:0] IDX_HYST_R1LOC = 8'h6d;
  localparam logic [7:0] IDX_HYST_R2 = 8'h6e;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h70;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
  localparam logic [7:0] IDX_FAN_STATE = 8'h72;
  localparam logic [7:0] IDX_START_R1 = 8'h74;
  localparam logic [7:0] IDX_START_LOC = 8'h75;
  localparam logic [7:0] IDX_START_R2 = 8'h76;

  // Per-channel index tables: 0 = remote 1, 1 = local, 2 = remote 2
  localparam logic [7:0] IDX_OP [NUM_CHAN] = '{IDX_OP_R1, IDX_OP_LOC,
                                               IDX_OP_R2};
  localparam logic [7:0] IDX_LOW [NUM_CHAN] = '{IDX_LOW_R1, IDX_LOW_LOC,
                                                IDX_LOW_R2};
  localparam logic [7:0] IDX_HIGH [NUM_CHAN] = '{IDX_HIGH_R1, IDX_HIGH_LOC,
                                                 IDX_HIGH_R2};
  localparam logic [7:0] IDX_CRIT [NUM_CHAN] = '{IDX_CRIT_R1, IDX_CRIT_LOC,
                                                 IDX_CRIT_R2};
  localparam logic [7:0] IDX_START [NUM_CHAN] = '{IDX_START_R1,
                                                  IDX_START_LOC,
                                                  IDX_START_R2};

  // Field positions
  localparam int HYST_HI_LSB = 4;
  localparam int HYST_LO_LSB = 0;
  localparam int KEEP_LSB = 5;
  localparam int EVT_LOW_LSB = 0;
  localparam int EVT_HIGH_LSB = 3;
  localparam int EVT_CRIT_LSB = 6;
  localparam int EVT_W = 9;

  // Reset values
  localparam logic [7:0] OP_RST = 8'ha4;
  localparam logic [7:0] LOW_RST = 8'h01;
  localparam logic [7:0] HIGH_RST = 8'h7f;
  localparam logic [7:0] CRIT_RST = 8'ha4;
  localparam logic [3:0] HYST_RST = 4'h4;
  localparam logic [2:0] KEEP_RST = 3'h0;
  localparam logic [7:0] START_RST = 8'h60;
  localparam logic [8:0] MASK_RST = 9'h000;

  typedef enum logic [1:0] {
    FAN_OFF = 2'b00,
    FAN_MIN = 2'b01,
    FAN_AUTO = 2'b10,
    FAN_FULL = 2'b11
  } tlfo_fan_mode_t;

  typedef struct packed {
    tlfo_fan_mode_t fan3;
    tlfo_fan_mode_t fan2;
    tlfo_fan_mode_t fan1;
  } tlfo_fan_cmd_t;

  typedef struct packed {
    logic [7:0] crit;
    logic [3:0] hyst;
    logic [7:0] start;
    logic [7:0] low;
    logic [7:0] high;
    logic keep;
  } tlfo_chan_cfg_t;

endpackage

//--- hdl/tlfo_channel.sv
// One temperature channel: critical latch, fan on/off band and limit events.
// Assumes sampleValid pulses once per fresh result on the same clock.
module tlfo_channel
  import tlfo_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic sampleValid,
  input wire logic [7:0] tempCode,
  input wire tlfo_chan_cfg_t cfg,
  output logic critActive_r,
  output logic fanOn_r,
  output logic lowEvt_r,
  output logic highEvt_r,
  output logic critEvt_r
);

  logic aboveCrit;
  logic belowCritRel;
  logic aboveStart;
  logic belowStart;
  logic belowStartRel;

  // Adding to the temperature avoids underflow of limit minus hysteresis
  assign aboveCrit = tempCode > cfg.crit;
  assign belowCritRel = ({1'b0, tempCode} + {5'h00, cfg.hyst}) <
                        {1'b0, cfg.crit};
  assign aboveStart = tempCode > cfg.start;
  assign belowStart = tempCode < cfg.start;
  assign belowStartRel = ({1'b0, tempCode} + {5'h00, cfg.hyst}) <
                         {1'b0, cfg.start};

  always_ff @(posedge clock) begin
    if (reset) begin
      critActive_r <= 1'b0;
    end else if (sampleValid) begin
      if (aboveCrit) begin
        critActive_r <= 1'b1; // [RL1] [RL18]
      end else if (belowCritRel) begin
        critActive_r <= 1'b0; // [RL2] [RL8]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      fanOn_r <= 1'b0;
    end else if (sampleValid) begin
      if (aboveStart) begin
        fanOn_r <= 1'b1;
      end else if (cfg.keep ? belowStart : belowStartRel) begin
        fanOn_r <= 1'b0; // [RL9] [RL11] [RL8]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      lowEvt_r <= 1'b0;
      highEvt_r <= 1'b0;
      critEvt_r <= 1'b0;
    end else begin
      lowEvt_r <= sampleValid && (tempCode < cfg.low); // [RL14]
      highEvt_r <= sampleValid && (tempCode > cfg.high); // [RL15]
      critEvt_r <= sampleValid && aboveCrit && !critActive_r;
    end
  end

  property p_crit_set;
    @(posedge clock) disable iff (reset)
      sampleValid && (tempCode > cfg.crit) |=> critActive_r;
  endproperty
  a_crit_set: assert property (p_crit_set) // [RL1]
    else $error("critical latch did not set");

  property p_crit_hold;
    @(posedge clock) disable iff (reset)
      critActive_r && !(sampleValid && belowCritRel) |=> critActive_r;
  endproperty
  a_crit_hold: assert property (p_crit_hold) // [RL2]
    else $error("critical latch released inside hysteresis");

  property p_keep_no_hyst;
    @(posedge clock) disable iff (reset)
      sampleValid && cfg.keep && belowStart |=> !fanOn_r;
  endproperty
  a_keep_no_hyst: assert property (p_keep_no_hyst) // [RL11]
    else $error("keep-spinning fan still used hysteresis");

endmodule

//--- hdl/tlfo_top.sv
// Thermal limit and fan override block with an APB register slave.
// Assumes temperature results arrive on the system clock with a valid pulse.
//
// Contract
// RL1: Any channel above its critical limit forces all fans to full duty.
// RL2: Full duty holds until temperature drops below critical minus hysteresis.
// RL3: Critical override is unmaskable and beats every fan control setting.
// RL4: Three critical-limit registers, each resetting to the 100 degree code.
// RL5: Hysteresis nibbles: remote1 high, local low, remote2 next high; default 4.
// RL6: Each hysteresis field is whole degrees, 1 to 15.
// RL7: Software should never write zero hysteresis, else fans toggle.
// RL8: Same hysteresis serves critical release and fan turn-off.
// RL9: Running fan stays on until below start temperature minus hysteresis.
// RL10: Keepalive bits 7,6,5 pick off or minimum duty for fans 3,2,1.
// RL11: With keepalive set, hysteresis has no effect below start temperature.
// RL12: Start temperature rises when zone runs cool, falls when hot.
// RL13: Three 8-bit operating-point registers, reset to the 100 degree code.
// RL14: Below low limit start temperature increases and an event is raised.
// RL15: Above high limit start temperature decreases and an event is raised.
// RL16: Six limit registers, lows reset to 0x01, highs to 0x7F.
// RL17: Adjustment never raises start temperature above the high limit.
// RL18: Each new channel result re-evaluates all that channel's comparisons.
module tlfo_top
  import tlfo_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CHAN-1:0] tempValid,
  input wire logic [NUM_CHAN-1:0][7:0] tempCode,
  output tlfo_fan_cmd_t fanCmd,
  output logic critOvertempSignal,
  output logic irq
);

  logic [7:0] opPoint_r [NUM_CHAN];
  logic [7:0] lowLim_r [NUM_CHAN];
  logic [7:0] highLim_r [NUM_CHAN];
  logic [7:0] critLim_r [NUM_CHAN];
  logic [3:0] hyst_r [NUM_CHAN];
  logic [7:0] startTemp_r [NUM_CHAN];
  logic [7:0] keepReg_r;
  logic [EVT_W-1:0] status_r;
  logic [EVT_W-1:0] mask_r;
  logic [EVT_W-1:0] evt;
  logic [NUM_CHAN-1:0] critActive;
  logic [NUM_CHAN-1:0] fanOn;
  logic [NUM_CHAN-1:0] keep;
  tlfo_fan_cmd_t fanCmd_r;
  tlfo_fan_mode_t mode_nxt [NUM_CHAN];
  logic critOvertemp_r;
  logic irq_r;
  logic [31:0] prdata_r;
  logic [31:0] readData;
  logic readHit;
  logic pready_r;
  logic pslverr_r;
  logic [7:0] regIdx;
  logic wrEn;
  logic anyCrit;

  assign regIdx = paddr[9:2];
  // Writes land on the edge that completes the access phase
  assign wrEn = psel && penable && pwrite && pready_r && readHit;
  assign keep = keepReg_r[KEEP_LSB +: NUM_CHAN]; // [RL10]
  assign anyCrit = |critActive;

  // Single wait state so read data can come from a flip-flop
  always_ff @(posedge clock) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (psel && penable && !pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= !readHit || (paddr[1:0] != 2'b00);
      prdata_r <= (pwrite || !readHit) ? 32'h0000_0000 : readData;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  always_comb begin
    readData = 32'h0000_0000;
    readHit = 1'b1;
    unique case (regIdx)
      IDX_OP_R1: readData[7:0] = opPoint_r[0];
      IDX_OP_LOC: readData[7:0] = opPoint_r[1];
      IDX_OP_R2: readData[7:0] = opPoint_r[2];
      IDX_LOW_R1: readData[7:0] = lowLim_r[0];
      IDX_HIGH_R1: readData[7:0] = highLim_r[0];
      IDX_LOW_LOC: readData[7:0] = lowLim_r[1];
      IDX_HIGH_LOC: readData[7:0] = highLim_r[1];
      IDX_LOW_R2: readData[7:0] = lowLim_r[2];
      IDX_HIGH_R2: readData[7:0] = highLim_r[2];
      IDX_KEEPALIVE: readData[7:0] = keepReg_r;
      IDX_CRIT_R1: readData[7:0] = critLim_r[0];
      IDX_CRIT_LOC: readData[7:0] = critLim_r[1];
      IDX_CRIT_R2: readData[7:0] = critLim_r[2];
      IDX_HYST_R1LOC: readData[7:0] = {hyst_r[0], hyst_r[1]}; // [RL5]
      IDX_HYST_R2: readData[7:0] = {hyst_r[2], 4'h0};
      IDX_IRQ_STATUS: readData[EVT_W-1:0] = status_r;
      IDX_IRQ_MASK: readData[EVT_W-1:0] = mask_r;
      IDX_FAN_STATE: readData[6:0] = {critOvertemp_r, fanCmd_r};
      IDX_START_R1: readData[7:0] = startTemp_r[0];
      IDX_START_LOC: readData[7:0] = startTemp_r[1];
      IDX_START_R2: readData[7:0] = startTemp_r[2];
      default: readHit = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      keepReg_r <= {KEEP_RST, 5'h00};
    end else if (wrEn && regIdx == IDX_KEEPALIVE) begin
      keepReg_r <= {pwdata[7:5], 5'h00};
    end
  end

  // Hysteresis fields; the nibble positions differ per channel
  always_ff @(posedge clock) begin
    if (reset) begin
      hyst_r[0] <= HYST_RST; // [RL5]
      hyst_r[1] <= HYST_RST;
      hyst_r[2] <= HYST_RST;
    end else if (wrEn && regIdx == IDX_HYST_R1LOC) begin
      hyst_r[0] <= pwdata[HYST_HI_LSB +: 4]; // [RL6]
      hyst_r[1] <= pwdata[HYST_LO_LSB +: 4];
    end else if (wrEn && regIdx == IDX_HYST_R2) begin
      hyst_r[2] <= pwdata[HYST_HI_LSB +: 4];
    end
  end

  generate
    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
      tlfo_chan_cfg_t cfg;
      logic tooHot;
      logic tooCool;

      always_ff @(posedge clock) begin
        if (reset) begin
          opPoint_r[i] <= OP_RST; // [RL13]
          lowLim_r[i] <= LOW_RST; // [RL16]
          highLim_r[i] <= HIGH_RST;
          critLim_r[i] <= CRIT_RST; // [RL4]
        end else if (wrEn) begin
          if (regIdx == IDX_OP[i]) begin
            opPoint_r[i] <= pwdata[7:0];
          end
          if (regIdx == IDX_LOW[i]) begin
            lowLim_r[i] <= pwdata[7:0];
          end
          if (regIdx == IDX_HIGH[i]) begin
            highLim_r[i] <= pwdata[7:0];
          end
          if (regIdx == IDX_CRIT[i]) begin
            critLim_r[i] <= pwdata[7:0];
          end
        end
      end

      assign tooHot = (tempCode[i] > highLim_r[i]) ||
                      (tempCode[i] > opPoint_r[i]);
      // Raise only inside the allowed window below high limit and op point
      assign tooCool = (tempCode[i] < lowLim_r[i]) &&
                       (tempCode[i] > startTemp_r[i]) &&
                       (startTemp_r[i] < highLim_r[i]) &&
                       (startTemp_r[i] < opPoint_r[i]);

      // Software write wins over a same-cycle adjustment step
      always_ff @(posedge clock) begin
        if (reset) begin
          startTemp_r[i] <= START_RST;
        end else if (wrEn && regIdx == IDX_START[i]) begin
          startTemp_r[i] <= pwdata[7:0];
        end else if (tempValid[i]) begin
          if (tooHot && startTemp_r[i] != 8'h00) begin
            startTemp_r[i] <= startTemp_r[i] - 8'h01; // [RL12] [RL15]
          end else if (tooCool) begin
            startTemp_r[i] <= startTemp_r[i] + 8'h01; // [RL14] [RL17]
          end
        end
      end

      assign cfg.crit = critLim_r[i];
      assign cfg.hyst = hyst_r[i];
      assign cfg.start = startTemp_r[i];
      assign cfg.low = lowLim_r[i];
      assign cfg.high = highLim_r[i];
      assign cfg.keep = keep[i];

      tlfo_channel u_chan (
        .clock(clock),
        .reset(reset),
        .sampleValid(tempValid[i]), // [RL18]
        .tempCode(tempCode[i]),
        .cfg(cfg),
        .critActive_r(critActive[i]),
        .fanOn_r(fanOn[i]),
        .lowEvt_r(evt[EVT_LOW_LSB + i]),
        .highEvt_r(evt[EVT_HIGH_LSB + i]),
        .critEvt_r(evt[EVT_CRIT_LSB + i])
      );

      // Critical override checked first, ahead of keepalive and auto
      always_comb begin
        if (anyCrit) begin
          mode_nxt[i] = FAN_FULL; // [RL1] [RL3]
        end else if (fanOn[i]) begin
          mode_nxt[i] = FAN_AUTO;
        end else if (keep[i]) begin
          mode_nxt[i] = FAN_MIN; // [RL10]
        end else begin
          mode_nxt[i] = FAN_OFF;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (reset) begin
      fanCmd_r <= '{fan3: FAN_OFF, fan2: FAN_OFF, fan1: FAN_OFF};
      critOvertemp_r <= 1'b0;
    end else begin
      fanCmd_r <= '{fan3: mode_nxt[2], fan2: mode_nxt[1],
                    fan1: mode_nxt[0]};
      critOvertemp_r <= anyCrit; // [RL1]
    end
  end

  assign fanCmd = fanCmd_r;
  assign critOvertempSignal = critOvertemp_r;

  // Write-one-to-clear; a new event in the same cycle keeps its bit
  always_ff @(posedge clock) begin
    if (reset) begin
      status_r <= '0;
      mask_r <= MASK_RST;
      irq_r <= 1'b0;
    end else begin
      if (wrEn && regIdx == IDX_IRQ_STATUS) begin
        status_r <= (status_r & ~pwdata[EVT_W-1:0]) | evt;
      end else begin
        status_r <= status_r | evt; // [RL14] [RL15]
      end
      if (wrEn && regIdx == IDX_IRQ_MASK) begin
        mask_r <= pwdata[EVT_W-1:0];
      end
      irq_r <= |(status_r & mask_r);
    end
  end

  assign irq = irq_r;

  property p_full_all_fans;
    @(posedge clock) disable iff (reset)
      anyCrit |=> fanCmd_r == '{fan3: FAN_FULL, fan2: FAN_FULL,
                                fan1: FAN_FULL};
  endproperty
  a_full_all_fans: assert property (p_full_all_fans) // [RL3]
    else $error("critical override did not drive every fan full");

  property p_keep_min;
    @(posedge clock) disable iff (reset)
      !anyCrit && !fanOn[0] |=> fanCmd_r.fan1 ==
        ($past(keep[0]) ? FAN_MIN : FAN_OFF);
  endproperty
  a_keep_min: assert property (p_keep_min) // [RL10]
    else $error("fan 1 idle mode ignores keepalive bit");

  property p_start_ceiling;
    @(posedge clock) disable iff (reset)
      tempValid[0] && !(wrEn && regIdx == IDX_START[0]) &&
      startTemp_r[0] >= highLim_r[0] && !$past(wrEn)
      |=> startTemp_r[0] <= $past(startTemp_r[0]);
  endproperty
  a_start_ceiling: assert property (p_start_ceiling) // [RL17]
    else $error("start temperature raised at or above high limit");

  property p_hot_lowers;
    @(posedge clock) disable iff (reset)
      tempValid[0] && tempCode[0] > highLim_r[0] &&
      startTemp_r[0] != 8'h00 && !wrEn
      |=> startTemp_r[0] == $past(startTemp_r[0]) - 8'h01;
  endproperty
  a_hot_lowers: assert property (p_hot_lowers) // [RL15]
    else $error("start temperature not lowered above high limit");

  property p_low_event;
    @(posedge clock) disable iff (reset)
      tempValid[0] && tempCode[0] < lowLim_r[0] ##1 !wrEn
      |=> status_r[EVT_LOW_LSB];
  endproperty
  a_low_event: assert property (p_low_event) // [RL14]
    else $error("low limit event not latched");

  property p_crit_reset_val;
    @(posedge clock)
      $fell(reset) |-> critLim_r[0] == CRIT_RST && opPoint_r[2] == OP_RST
        && lowLim_r[1] == LOW_RST && highLim_r[1] == HIGH_RST;
  endproperty
  a_crit_reset_val: assert property (p_crit_reset_val) // [RL4]
    else $error("limit register reset value wrong");

  property p_hyst_reset_val;
    @(posedge clock)
      $fell(reset) |-> hyst_r[0] == HYST_RST && hyst_r[2] == HYST_RST;
  endproperty
  a_hyst_reset_val: assert property (p_hyst_reset_val) // [RL5]
    else $error("hysteresis reset value wrong");

  property p_apb_wait;
    @(posedge clock) disable iff (reset)
      psel && penable && !pready_r |=> pready_r ##1 !pready_r;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("register access not answered after one wait state");

  // Set must win even when a clear lands in the same cycle
  property p_high_sticky;
    @(posedge clock) disable iff (reset)
      evt[EVT_HIGH_LSB] |=> status_r[EVT_HIGH_LSB];
  endproperty
  a_high_sticky: assert property (p_high_sticky) // [RL15]
    else $error("high limit event lost from status");

  property p_irq_follows;
    @(posedge clock) disable iff (reset)
      (|(status_r & mask_r)) |=> irq_r;
  endproperty
  a_irq_follows: assert property (p_irq_follows) // [RL14]
    else $error("interrupt not raised for unmasked status");

  property p_irq_quiet;
    @(posedge clock) disable iff (reset)
      !(|(status_r & mask_r)) |=> !irq_r;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) // [RL14]
    else $error("interrupt raised with nothing unmasked");

endmodule

//--- testbench/tlfo_temp_source.sv
// Stand-in for the monitoring cycle that delivers temperature results.
// Assumes send is called just after a rising edge of clock.
module tlfo_temp_source
  import tlfo_pkg::*;
(
  input wire logic clock,
  output logic [NUM_CHAN-1:0] tempValid,
  output logic [NUM_CHAN-1:0][7:0] tempCode
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    tempValid = '0;
    tempCode = '0;
  end

  // Code means nothing outside its pulse, so it is garbled afterwards
  task send(input int ch, input logic [7:0] code);
    tempValid[ch] <= 1'b1;
    tempCode[ch] <= code;
    @(posedge clock);
    tempValid[ch] <= 1'b0;
    tempCode[ch] <= ~code;
    @(posedge clock);
  endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the thermal limit and fan override block.
// Assumes an APB slave with handshake on pready and a 100 MHz clock.
module testbench
  import tlfo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock, reset, psel, penable, pwrite, pready, pslverr, irq, err;
  logic critOvertempSignal;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_CHAN-1:0] tempValid;
  logic [NUM_CHAN-1:0][7:0] tempCode;
  tlfo_fan_cmd_t fanCmd;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  localparam logic [7:0] RIDX [14] = '{IDX_OP_R1, IDX_OP_R2, IDX_LOW_R1,
    IDX_HIGH_LOC, IDX_LOW_R2, IDX_HIGH_R2, IDX_CRIT_R1, IDX_CRIT_LOC,
    IDX_CRIT_R2, IDX_HYST_R1LOC, IDX_HYST_R2, IDX_KEEPALIVE, IDX_IRQ_MASK,
    IDX_IRQ_STATUS};
  localparam logic [7:0] RVAL [14] = '{8'ha4, 8'ha4, 8'h01, 8'h7f, 8'h01,
    8'h7f, 8'ha4, 8'ha4, 8'ha4, 8'h44, 8'h40, 8'h00, 8'h00, 8'h00};

  tlfo_top dut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tempValid(tempValid), .tempCode(tempCode), .fanCmd(fanCmd),
    .critOvertempSignal(critOvertempSignal), .irq(irq));

  tlfo_temp_source src (.clock(clock), .tempValid(tempValid),
    .tempCode(tempCode));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Whole run needs a few hundred cycles; this leaves wide margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h00_0000, d});
    chk("write error", 32'h0, {31'h0, err});
  endtask

  task automatic rdc(input string what, input logic [7:0] idx,
                     input logic [7:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(what, {24'h00_0000, exp}, rd);
    chk("read error", 32'h0, {31'h0, err});
  endtask

  task automatic smp(input int ch, input logic [7:0] code);
    src.send(ch, code);
    repeat (3) @(posedge clock);
  endtask

  task automatic fan(input string what, input logic [5:0] exp);
    chk(what, {26'h000_0000, exp}, {26'h000_0000, fanCmd});
  endtask

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 14; i++) begin
      rdc("reset value", RIDX[i], RVAL[i]);
    end
    // Critical override on local channel with every fan kept at minimum
    wr(IDX_KEEPALIVE, 8'he0);
    wr(IDX_CRIT_LOC, 8'h50);
    smp(1, 8'h51);
    fan("crit full", 6'h3f);
    chk("crit pin", 32'h1, {31'h0, critOvertempSignal});
    rdc("fan state", IDX_FAN_STATE, 8'h7f);
    rdc("crit event", IDX_IRQ_STATUS, 8'h80);
    chk("irq masked", 32'h0, {31'h0, irq});
    smp(1, 8'h4d);
    fan("crit held", 6'h3f);
    smp(1, 8'h4b);
    fan("crit released", 6'h15);
    chk("crit pin off", 32'h0, {31'h0, critOvertempSignal});
    wr(IDX_IRQ_MASK, 8'h80);
    repeat (2) @(posedge clock);
    chk("irq", 32'h1, {31'h0, irq});
    wr(IDX_IRQ_STATUS, 8'h80);
    repeat (2) @(posedge clock);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc("status cleared", IDX_IRQ_STATUS, 8'h00);
    wr(IDX_CRIT_LOC, 8'ha4);
    wr(IDX_KEEPALIVE, 8'h00);
    // Fan on/off band around the start temperature 0x60, hysteresis 4
    smp(0, 8'h61);
    fan("fan on", 6'h02);
    smp(0, 8'h5e);
    fan("fan held", 6'h02);
    smp(0, 8'h5b);
    fan("fan off", 6'h00);
    for (int k = 0; k < 3; k++) begin
      wr(IDX_KEEPALIVE, 8'h20 << k);
      smp(k, 8'h61);
      fan("keep on", 6'h02 << (2 * k));
      smp(k, 8'h5f);
      fan("keep min", 6'h01 << (2 * k));
    end
    wr(IDX_KEEPALIVE, 8'h00);
    // Start temperature steps on remote 1
    wr(IDX_HIGH_R1, 8'h70);
    smp(0, 8'h71);
    rdc("start down", IDX_START_R1, 8'h5f);
    rdc("high event", IDX_IRQ_STATUS, 8'h08);
    wr(IDX_LOW_R1, 8'h66);
    smp(0, 8'h62);
    rdc("start up", IDX_START_R1, 8'h60);
    rdc("low event", IDX_IRQ_STATUS, 8'h09);
    wr(IDX_START_R1, 8'h61);
    wr(IDX_HIGH_R1, 8'h62);
    smp(0, 8'h62);
    smp(0, 8'h62);
    rdc("start cap", IDX_START_R1, 8'h62);
    wr(IDX_IRQ_STATUS, 8'hff);
    rdc("status w1c", IDX_IRQ_STATUS, 8'h00);
    // Hysteresis fields are only ever given nonzero values
    wr(IDX_HYST_R1LOC, 8'h2f);
    rdc("hyst write", IDX_HYST_R1LOC, 8'h2f);
    wr(IDX_HYST_R2, 8'hf3);
    rdc("hyst r2 write", IDX_HYST_R2, 8'hf0);
    apb(1'b0, 8'h00, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    finish_test();
  end
endmodule
